/* File: dv/host_pins.sv */
// Host GPIO model driving the shared select pins
`timescale 1ns/100ps
module host_pins (
    input wire logic clock_in,
    input wire logic drive_in,
    input wire logic [1:0] code_in,
    output logic bit1_out,
    output logic bit0_out
);
    logic [1:0] held = 2'h0;
    // Code moves just after a rising edge and then stays put
    always @(posedge clock_in) held <= code_in;
    // Released pins fall to the pull-down level
    assign bit1_out = drive_in ? held[1] : 1'b0;
    assign bit0_out = drive_in ? held[0] : 1'b0;
endmodule

/* File: dv/pin_ctrl_sva.sv */
// Concurrent checks on the control-pin logic ports
`timescale 1ns/100ps
module pin_ctrl_sva
    import pin_ctrl_pkg::*;
#(
    parameter int PAIRS = NUM_PAIRS
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic ref_source_select_pin_in,
    input wire logic shutdown_or_enable_pin_in,
    input wire logic config_select_bit1_in,
    input wire logic config_select_bit0_in,
    input wire logic override_valid_in,
    input wire logic ref_invert_in,
    input wire logic manual_switch_mode_in,
    input wire logic auto_ref_source_in,
    input wire logic pin_role_select_bit_in,
    input wire logic ref_source_out,
    input wire logic power_down_out,
    input wire logic serial_mode_out,
    input wire logic sda_in_out,
    input wire logic scl_in_out,
    input wire logic [PAIRS-1:0] pair_diff_mode_in,
    input wire logic [PAIRS-1:0] out_pos_out,
    input wire logic [PAIRS-1:0] out_neg_out,
    input wire logic [PAIRS-1:0] out_drive_en_out
);
    wire logic sd_role = override_valid_in && pin_role_select_bit_in;
    wire logic manual = !override_valid_in || manual_switch_mode_in;
    wire logic inv = override_valid_in && ref_invert_in;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    property p_pd_on; sd_role && shutdown_or_enable_pin_in |=> power_down_out; endproperty
    a_pd_on: assert property (p_pd_on) else $error("shutdown not entered");
    property p_pd_off; !sd_role |=> !power_down_out; endproperty
    a_pd_off: assert property (p_pd_off) else $error("power down in enable role");
    property p_ref_pin;
        manual |=> ref_source_out == ($past(ref_source_select_pin_in) ^ $past(inv));
    endproperty
    a_ref_pin: assert property (p_ref_pin) else $error("reference pin choice wrong");
    property p_ref_auto; !manual |=> ref_source_out == $past(auto_ref_source_in); endproperty
    a_ref_auto: assert property (p_ref_auto) else $error("automatic choice wrong");
    property p_shut;
        power_down_out && $stable(pair_diff_mode_in) |=> out_neg_out == '0
            && out_drive_en_out == '1 && out_pos_out == $past(pair_diff_mode_in);
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown output levels wrong");
    property p_oe_off;
        (!override_valid_in && shutdown_or_enable_pin_in) [*2] |=> out_drive_en_out == '0;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("default disable wrong");
    property p_serial;
        serial_mode_out |=> sda_in_out == $past(config_select_bit1_in)
            && scl_in_out == $past(config_select_bit0_in);
    endproperty
    a_serial: assert property (p_serial) else $error("serial lines not passed");
    property p_strap; serial_mode_out |=> serial_mode_out; endproperty
    a_strap: assert property (p_strap) else $error("strap choice not held");
    c_pd: cover property (power_down_out);
    c_serial: cover property (serial_mode_out);
    c_tristate: cover property (out_drive_en_out == '0);
endmodule

bind clock_gen_control_pin_logic pin_ctrl_sva #(.PAIRS(PAIRS)) i_sva (.*);

/* File: dv/tb.sv */
// Self-checking bench for the control-pin logic
`timescale 1ns/100ps
module tb
    import pin_ctrl_pkg::*;
;
    localparam int P = NUM_PAIRS;
    logic clock_in = 1'b0, reset_n_in = 1'b0, rsel = 1'b0, sd = 1'b0, strap = 1'b1;
    logic ovr = 1'b0, inv = 1'b0, man = 1'b1, aut = 1'b0, role = 1'b0, pol = 1'b0, drv = 1'b1;
    logic [1:0] code = 2'h0;
    logic [P-1:0] trs = '1, lvl = '0, clk = '0, dif = '0;
    logic b1, b0, ref_o, pd_o, ser_o, sda_o, scl_o;
    logic [P-1:0] pos_o, neg_o, den_o;
    logic [1:0] cfg_o;
    integer seed = 32'h5ee2;
    int errors = 0, n_tests = 0;
    always #4 clock_in = ~clock_in;
    host_pins i_host (.clock_in(clock_in), .drive_in(drv), .code_in(code),
        .bit1_out(b1), .bit0_out(b0));
    clock_gen_control_pin_logic #(.PAIRS(P)) i_dut (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .ref_source_select_pin_in(rsel),
        .shutdown_or_enable_pin_in(sd), .config_select_bit1_in(b1), .config_select_bit0_in(b0),
        .serial_mode_strap_in(strap), .override_valid_in(ovr), .ref_invert_in(inv),
        .manual_switch_mode_in(man), .auto_ref_source_in(aut), .pin_role_select_bit_in(role),
        .enable_polarity_bit_in(pol), .disable_tristate_in(trs), .disable_level_in(lvl),
        .pair_clock_in(clk), .pair_diff_mode_in(dif), .ref_source_out(ref_o),
        .power_down_out(pd_o), .out_pos_out(pos_o), .out_neg_out(neg_o),
        .out_drive_en_out(den_o), .config_select_out(cfg_o), .serial_mode_out(ser_o),
        .sda_in_out(sda_o), .scl_in_out(scl_o)
    );
    // Pos, neg, drive enable; levels zero where the pair is tri-stated
    function automatic logic [2:0] exp_pair(int i);
        logic role_e;
        role_e = ovr & role;
        if (role_e && sd) return {dif[i], 2'b01};
        if (role_e || sd == (ovr & pol)) return {clk[i], clk[i] ^ dif[i], 1'b1};
        if (!ovr || trs[i]) return 3'h0;
        return {lvl[i], lvl[i] ^ dif[i], 1'b1};
    endfunction
    task automatic chk(logic [2:0] got, logic [2:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic do_reset(logic s);
        strap = s;
        reset_n_in = 1'b0;
        repeat (10) @(negedge clock_in);
        chk({ser_o, sda_o, scl_o}, 3'h3);
        reset_n_in = 1'b1;
        repeat (2) @(negedge clock_in);
    endtask
    // Corner: shutdown entered from run, pin to power down one edge, outputs two
    task automatic walk_shutdown();
        logic [31:0] r;
        logic [2:0] e [P];
        r = $random(seed);
        ovr = 1'b1;
        role = 1'b1;
        sd = 1'b0;
        clk = '1;
        dif = r[P-1:0];
        repeat (3) @(negedge clock_in);
        for (int i = 0; i < P; i++) begin
            e[i] = exp_pair(i);
        end
        sd = 1'b1;
        @(negedge clock_in);
        chk({2'h0, pd_o}, 3'h1);
        for (int i = 0; i < P; i++) begin
            chk({pos_o[i], neg_o[i], den_o[i]}, e[i]);
        end
        @(negedge clock_in);
        for (int i = 0; i < P; i++) begin
            chk({pos_o[i], neg_o[i], den_o[i]}, exp_pair(i));
        end
    endtask
    // Random settings held long enough for every path to settle
    task automatic rnd(logic mode);
        logic [31:0] r;
        logic [2:0] e;
        logic [1:0] b;
        r = $random(seed);
        {ovr, inv, man, aut, role, pol, rsel, sd, drv, strap, code} = r[11:0];
        r = $random(seed);
        {trs, lvl, clk, dif} = r[4*P-1:0];
        b = drv ? code : 2'h0;
        repeat (3) @(negedge clock_in);
        e[0] = (!ovr || man) ? rsel ^ (ovr & inv) : aut;
        chk({1'b0, ref_o, pd_o}, {1'b0, e[0], ovr & role & sd});
        chk({ser_o, sda_o, scl_o}, mode ? {1'b1, b} : 3'h3);
        chk({1'b0, cfg_o}, mode ? {1'b0, CONFIG_RESET} : {1'b0, b});
        for (int i = 0; i < P; i++) begin
            e = exp_pair(i);
            chk({e[0] ? {pos_o[i], neg_o[i]} : 2'h0, den_o[i]}, e);
        end
    endtask
    initial begin
        do_reset(1'b1);
        walk_shutdown();
        repeat (150) rnd(1'b0);
        do_reset(STRAP_SERIAL);
        repeat (150) rnd(1'b1);
        end_of_test();
    end
    initial begin
        #20000;
        errors++;
        end_of_test();
    end
endmodule

/* File: hw/clock_gen_control_pin_logic.sv */
// Control-pin logic: reference select, shutdown/enable pin, shared select/serial pins
`timescale 1ns/100ps
module clock_gen_control_pin_logic
    import pin_ctrl_pkg::*;
#(
    parameter int PAIRS = NUM_PAIRS
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    // Pins
    input wire logic ref_source_select_pin_in,
    input wire logic shutdown_or_enable_pin_in,
    input wire logic config_select_bit1_in,
    input wire logic config_select_bit0_in,
    input wire logic serial_mode_strap_in,
    // Programmed configuration and its validity
    input wire logic override_valid_in,
    input wire logic ref_invert_in,
    input wire logic manual_switch_mode_in,
    input wire logic auto_ref_source_in,
    input wire logic pin_role_select_bit_in,
    input wire logic enable_polarity_bit_in,
    input wire logic [PAIRS-1:0] disable_tristate_in,
    input wire logic [PAIRS-1:0] disable_level_in,
    // Clock outputs and differential-mode bits from the output stage before gating
    input wire logic [PAIRS-1:0] pair_clock_in,
    input wire logic [PAIRS-1:0] pair_diff_mode_in,
    // Results
    output logic ref_source_out,
    output logic power_down_out,
    output logic [PAIRS-1:0] out_pos_out,
    output logic [PAIRS-1:0] out_neg_out,
    output logic [PAIRS-1:0] out_drive_en_out,
    output logic [1:0] config_select_out,
    output logic serial_mode_out,
    output logic sda_in_out,
    output logic scl_in_out
);
    logic strap_value;
    logic strap_done;
    logic ref_source;
    logic power_down;
    logic out_disabled;
    logic [PAIRS-1:0] out_pos;
    logic [PAIRS-1:0] out_neg;
    logic [PAIRS-1:0] out_en;
    logic [1:0] config_select;
    logic sda_value;
    logic scl_value;
    logic next_ref_source;
    logic next_power_down;
    logic next_out_disabled;
    logic [PAIRS-1:0] next_out_pos;
    logic [PAIRS-1:0] next_out_neg;
    logic [PAIRS-1:0] next_out_en;
    logic [1:0] next_config_select;
    logic next_sda_value;
    logic next_scl_value;
    logic eff_invert;
    logic eff_manual;
    logic eff_role;
    logic eff_polarity;
    logic [PAIRS-1:0] eff_tristate;
    logic [PAIRS-1:0] eff_level;
    logic enable_active;
    out_state_t out_state;

    strap_latch u_strap (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .strap_in(serial_mode_strap_in),
        .strap_out(strap_value),
        .captured_out(strap_done)
    );

    // ----------------------------------------------------------------
    // Effective configuration
    // ----------------------------------------------------------------
    always_comb begin
        if (override_valid_in) begin
            eff_invert = ref_invert_in;
            eff_manual = manual_switch_mode_in;
            eff_role = pin_role_select_bit_in;
            eff_polarity = enable_polarity_bit_in;
            eff_tristate = disable_tristate_in;
            eff_level = disable_level_in;
        end else begin
            eff_invert = REF_INVERT_RESET;
            eff_manual = MANUAL_SWITCH_RESET;
            eff_role = ROLE_RESET;
            eff_polarity = POLARITY_RESET;
            eff_tristate = {PAIRS{DISABLE_TRISTATE_RESET}};
            eff_level = '0;
        end
    end

    // ----------------------------------------------------------------
    // Reference source and pin role decode
    // ----------------------------------------------------------------
    always_comb begin
        if (eff_manual) begin
            next_ref_source = ref_source_select_pin_in ^ eff_invert;
        end else begin
            next_ref_source = auto_ref_source_in;
        end
        // Active-high when polarity bit set, else active-low
        enable_active = eff_polarity ? shutdown_or_enable_pin_in
                                     : !shutdown_or_enable_pin_in;
        if (eff_role == ROLE_SHUTDOWN) begin
            // Shutdown role: pin high shuts down, polarity ignored
            next_power_down = shutdown_or_enable_pin_in;
            next_out_disabled = 1'b0;
        end else begin
            next_power_down = 1'b0;
            next_out_disabled = !enable_active;
        end
    end

    always_comb begin
        if (power_down) begin
            out_state = OUT_SHUTDOWN;
        end else if (out_disabled) begin
            out_state = OUT_DISABLED;
        end else begin
            out_state = OUT_RUN;
        end
    end

    // ----------------------------------------------------------------
    // Output gating per pair
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < PAIRS; i++) begin : g_pair
            always_comb begin
                case (out_state)
                    OUT_SHUTDOWN: begin
                        next_out_en[i] = 1'b1;
                        if (pair_diff_mode_in[i]) begin
                            next_out_pos[i] = 1'b1;
                            next_out_neg[i] = 1'b0;
                        end else begin
                            next_out_pos[i] = 1'b0;
                            next_out_neg[i] = 1'b0;
                        end
                    end
                    OUT_DISABLED: begin
                        next_out_en[i] = !eff_tristate[i];
                        next_out_pos[i] = eff_level[i];
                        next_out_neg[i] = pair_diff_mode_in[i] ? !eff_level[i] : eff_level[i];
                    end
                    OUT_RUN: begin
                        next_out_en[i] = 1'b1;
                        next_out_pos[i] = pair_clock_in[i];
                        next_out_neg[i] = pair_diff_mode_in[i] ? !pair_clock_in[i]
                                                               : pair_clock_in[i];
                    end
                    default: begin
                        next_out_en[i] = 1'b0;
                        next_out_pos[i] = 1'b0;
                        next_out_neg[i] = 1'b0;
                    end
                endcase
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Shared select/serial pins
    // ----------------------------------------------------------------
    always_comb begin
        if (strap_done && strap_value != STRAP_SERIAL) begin
            // Host keeps the code static while in use
            next_config_select = {config_select_bit1_in, config_select_bit0_in};
            next_sda_value = 1'b1;
            next_scl_value = 1'b1;
        end else begin
            next_config_select = config_select;
            next_sda_value = config_select_bit1_in;
            next_scl_value = config_select_bit0_in;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ref_source <= REF_CRYSTAL;
            power_down <= 1'b0;
            out_disabled <= 1'b0;
            out_pos <= '0;
            out_neg <= '0;
            out_en <= '0;
            config_select <= CONFIG_RESET;
            sda_value <= 1'b1;
            scl_value <= 1'b1;
        end else begin
            ref_source <= next_ref_source;
            power_down <= next_power_down;
            out_disabled <= next_out_disabled;
            out_pos <= next_out_pos;
            out_neg <= next_out_neg;
            out_en <= next_out_en;
            config_select <= next_config_select;
            sda_value <= next_sda_value;
            scl_value <= next_scl_value;
        end
    end

    assign ref_source_out = ref_source;
    assign power_down_out = power_down;
    assign out_pos_out = out_pos;
    assign out_neg_out = out_neg;
    assign out_drive_en_out = out_en;
    assign config_select_out = config_select;
    assign serial_mode_out = strap_done && (strap_value == STRAP_SERIAL);
    assign sda_in_out = sda_value;
    assign scl_in_out = scl_value;
endmodule

/* File: hw/pin_ctrl_pkg.sv */
// Package: constants for the clock generator control-pin logic
package pin_ctrl_pkg;
    // Reference source codes
    localparam logic REF_CRYSTAL = 1'b0;
    localparam logic REF_EXTERNAL = 1'b1;
    // Defaults of programmable bits, and the shutdown role code
    localparam logic REF_INVERT_RESET = 1'b0;
    localparam logic ROLE_SHUTDOWN = 1'b1;
    localparam logic ROLE_RESET = 1'b0;
    localparam logic POLARITY_RESET = 1'b0;
    localparam logic DISABLE_TRISTATE_RESET = 1'b1;
    localparam logic MANUAL_SWITCH_RESET = 1'b1;
    // Strap value that selects the serial interface
    localparam logic STRAP_SERIAL = 1'b0;
    localparam int NUM_PAIRS = 4;
    localparam logic [1:0] CONFIG_RESET = 2'h0;
    typedef enum logic [1:0] {OUT_RUN, OUT_DISABLED, OUT_SHUTDOWN} out_state_t;
endpackage

/* File: hw/strap_latch.sv */
// Capture of the serial-mode strap after reset release
`timescale 1ns/100ps
module strap_latch
    import pin_ctrl_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic strap_in,
    output logic strap_out,
    output logic captured_out
);
    logic captured;
    logic value;
    logic next_captured;
    logic next_value;

    always_comb begin
        next_captured = 1'b1;
        next_value = captured ? value : strap_in;
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            captured <= 1'b0;
            value <= STRAP_SERIAL;
        end else begin
            captured <= next_captured;
            value <= next_value;
        end
    end

    assign strap_out = value;
    assign captured_out = captured;
endmodule
